// ===== hw/srsc_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Regulator-rail lockout on holds outputs off until both its fault flags are cleared.
// - Battery-rail lockout on holds outputs off until both its flags clear; else restore.
// - In standby, both lockout settings are ignored and treated as disabled.
// - Regulator-rail overvoltage cuts its outputs only while its cut enable is set.
// - Regulator-rail undervoltage cuts its outputs only while its cut enable is set.
// - Main regulator undervoltage caused by regulator-rail undervoltage forces fail-safe, outputs off.
// - Battery overvoltage cuts outputs if enabled; if disabled, cuts once charge pump low.
// - Battery-rail undervoltage cuts its outputs only while its cut enable is set.
// - Main regulator undervoltage caused by battery undervoltage forces fail-safe, all outputs off.
// - In active mode, supply below warning threshold raises interrupt and sets warning flag.
// - Warning threshold is 10 bits; zero disables it and is the reset value.
module srsc_top (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Serial register port, sampled on clk
  input  wire logic       spiCsN,
  input  wire logic       spiClk,
  input  wire logic       spiDataIn,
  output logic            spiDataOut,
  // Rail comparators and converter
  input  wire logic       regRailUv,
  input  wire logic       regRailOv,
  input  wire logic       batRailUv,
  input  wire logic       batRailOv,
  input  wire logic       chargePumpLow,
  input  wire logic       main5vUv,
  input  wire logic [9:0] regSupplyCode,
  // Operating mode
  input  wire logic       activeMode,
  input  wire logic       standbyMode,
  // Supervision results
  output logic            regRailOutOn,
  output logic            batRailOutOn,
  output logic            failSafe,
  output logic            interruptOutN
);

  logic        sckPrev_q;
  logic        csPrev_q;
  logic [31:0] rxShift_q;
  logic [5:0]  bitCnt_q;
  logic [23:0] txShift_q;
  logic        spiDataOut_q;
  logic [5:0]  cutCfg_q;
  logic [9:0]  warnTh_q;
  logic        warnFlag_q;
  logic        regRailOutOn_q;
  logic        batRailOutOn_q;
  logic        failSafe_q;
  logic        interruptOutN_q;

  logic        sckRise;
  logic        sckFall;
  logic        csFall;
  logic        csRise;
  logic        commit;
  logic [7:0]  header;
  logic [23:0] readData;
  logic [23:0] ctrlWord;
  logic [23:0] statWord;
  logic        wrCtrl;
  logic        wrStat;
  logic [23:0] wrData;
  logic        regLockEff;
  logic        batLockEff;
  logic        regUvFlag;
  logic        regOvFlag;
  logic        batUvFlag;
  logic        batOvFlag;
  logic        regGuardOn;
  logic        batGuardOn;
  logic        failNow;
  logic        warnNow;
  logic        regOvCutEn;
  logic        regUvCutEn;
  logic        batOvCutEn;
  logic        batUvCutEn;

  // Edge detection on the serial pins; inputs are already synchronous
  assign sckRise = !spiCsN && spiClk && !sckPrev_q;
  assign sckFall = !spiCsN && !spiClk && sckPrev_q;
  assign csFall  = !spiCsN && csPrev_q;
  assign csRise  = spiCsN && !csPrev_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      sckPrev_q <= 1'b0;
      csPrev_q  <= 1'b1;
    end else begin
      sckPrev_q <= spiClk;
      csPrev_q  <= spiCsN;
    end
  end

  // Receive shifter; bits beyond a full frame are dropped so the frame stays aligned
  always_ff @(posedge clk) begin
    if (srst) begin
      rxShift_q <= 32'h0000_0000;
      bitCnt_q  <= 6'h00;
    end else if (csFall) begin
      bitCnt_q <= 6'h00;
    end else if (sckRise && bitCnt_q != srsc_pkg::FRAME_LAST) begin
      rxShift_q <= {rxShift_q[30:0], spiDataIn};
      bitCnt_q  <= bitCnt_q + 6'h01;
    end
  end

  // Header as it stands once its eighth bit arrives
  assign header = {rxShift_q[6:0], spiDataIn};

  // Register images seen by reads
  assign ctrlWord = {cutCfg_q, 8'h00, warnTh_q};
  assign statWord = {19'h0_0000, batOvFlag, batUvFlag, regOvFlag, regUvFlag, warnFlag_q};

  always_comb begin
    readData = 24'h00_0000;
    if (header[7:6] == srsc_pkg::OP_READ || header[7:6] == srsc_pkg::OP_WRITE) begin
      if (header[5:0] == srsc_pkg::SUPPLY_CTRL_OFFS) begin
        readData = ctrlWord;
      end else if (header[5:0] == srsc_pkg::SECOND_STAT_OFFS) begin
        readData = statWord;
      end
    end
  end

  // Transmit shifter: loaded after the header, shifted on falling edges
  always_ff @(posedge clk) begin
    if (srst) begin
      txShift_q    <= 24'h00_0000;
      spiDataOut_q <= 1'b0;
    end else if (csFall) begin
      txShift_q    <= 24'h00_0000;
      spiDataOut_q <= 1'b0;
    end else if (sckRise && bitCnt_q == srsc_pkg::HEAD_LAST) begin
      txShift_q <= readData;
    end else if (sckFall) begin
      spiDataOut_q <= txShift_q[23];
      txShift_q    <= {txShift_q[22:0], 1'b0};
    end
  end

  // A write takes effect only on chip-select release after at least a full frame
  assign commit = csRise && bitCnt_q == srsc_pkg::FRAME_LAST;
  assign wrData = rxShift_q[23:0];
  assign wrCtrl = commit && rxShift_q[srsc_pkg::OP_HI:srsc_pkg::OP_LO] == srsc_pkg::OP_WRITE
                  && rxShift_q[srsc_pkg::ADDR_HI:srsc_pkg::ADDR_LO] == srsc_pkg::SUPPLY_CTRL_OFFS;
  assign wrStat = commit && rxShift_q[srsc_pkg::OP_HI:srsc_pkg::OP_LO] == srsc_pkg::OP_WRITE
                  && rxShift_q[srsc_pkg::ADDR_HI:srsc_pkg::ADDR_LO] == srsc_pkg::SECOND_STAT_OFFS;

  // Supply supervision control register; reserved bits are not stored
  always_ff @(posedge clk) begin
    if (srst) begin
      cutCfg_q <= srsc_pkg::CUT_FIELDS_RST;
      warnTh_q <= srsc_pkg::WARN_TH_RST;
    end else if (wrCtrl) begin
      cutCfg_q <= wrData[srsc_pkg::REG_LOCK_BIT:srsc_pkg::BAT_UV_CUT_BIT];
      warnTh_q <= wrData[srsc_pkg::WARN_TH_HI:srsc_pkg::WARN_TH_LO];
    end
  end

  // Standby overrides lockout so contacts stay supplied for wake-up
  assign regLockEff = cutCfg_q[srsc_pkg::REG_LOCK_BIT - srsc_pkg::BAT_UV_CUT_BIT]
                      && !standbyMode;
  assign batLockEff = cutCfg_q[srsc_pkg::BAT_LOCK_BIT - srsc_pkg::BAT_UV_CUT_BIT]
                      && !standbyMode;

  // Cut enables by name, for the checks at the bottom
  assign regOvCutEn = cutCfg_q[srsc_pkg::REG_OV_CUT_BIT - srsc_pkg::BAT_UV_CUT_BIT];
  assign regUvCutEn = cutCfg_q[srsc_pkg::REG_UV_CUT_BIT - srsc_pkg::BAT_UV_CUT_BIT];
  assign batOvCutEn = cutCfg_q[srsc_pkg::BAT_OV_CUT_BIT - srsc_pkg::BAT_UV_CUT_BIT];
  assign batUvCutEn = cutCfg_q[0];

  // Regulator rail never sees the charge-pump exception
  srsc_rail_guard u_reg_guard (
    .clk           (clk),
    .srst          (srst),
    .underVolt     (regRailUv),
    .overVolt      (regRailOv),
    .chargePumpLow (1'b0),
    .lockEn        (regLockEff),
    .overCutEn     (cutCfg_q[srsc_pkg::REG_OV_CUT_BIT - srsc_pkg::BAT_UV_CUT_BIT]),
    .underCutEn    (cutCfg_q[srsc_pkg::REG_UV_CUT_BIT - srsc_pkg::BAT_UV_CUT_BIT]),
    .clrUnder      (wrStat && wrData[srsc_pkg::ST_REG_UV_BIT]),
    .clrOver       (wrStat && wrData[srsc_pkg::ST_REG_OV_BIT]),
    .underFlag     (regUvFlag),
    .overFlag      (regOvFlag),
    .outputsOn     (regGuardOn)
  );

  srsc_rail_guard u_bat_guard (
    .clk           (clk),
    .srst          (srst),
    .underVolt     (batRailUv),
    .overVolt      (batRailOv),
    .chargePumpLow (chargePumpLow),
    .lockEn        (batLockEff),
    .overCutEn     (cutCfg_q[srsc_pkg::BAT_OV_CUT_BIT - srsc_pkg::BAT_UV_CUT_BIT]),
    .underCutEn    (cutCfg_q[0]),
    .clrUnder      (wrStat && wrData[srsc_pkg::ST_BAT_UV_BIT]),
    .clrOver       (wrStat && wrData[srsc_pkg::ST_BAT_OV_BIT]),
    .underFlag     (batUvFlag),
    .overFlag      (batOvFlag),
    .outputsOn     (batGuardOn)
  );

  // Fail-safe ignores every cut enable; it lasts while the main regulator and either rail are undervoltage
  assign failNow = main5vUv && (regRailUv || batRailUv);

  always_ff @(posedge clk) begin
    if (srst) begin
      failSafe_q     <= 1'b0;
      regRailOutOn_q <= 1'b0;
      batRailOutOn_q <= 1'b0;
    end else begin
      failSafe_q     <= failNow;
      regRailOutOn_q <= regGuardOn && !failNow;
      batRailOutOn_q <= batGuardOn && !failNow;
    end
  end

  // Early warning: linear code compare, zero threshold switches it off
  assign warnNow = activeMode && warnTh_q != srsc_pkg::WARN_TH_RST
                   && regSupplyCode < warnTh_q;

  // Warning flag is sticky; a new warning beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      warnFlag_q      <= 1'b0;
      interruptOutN_q <= 1'b1;
    end else begin
      interruptOutN_q <= !warnNow;
      if (warnNow) begin
        warnFlag_q <= 1'b1;
      end else if (wrStat && wrData[srsc_pkg::ST_WARN_BIT]) begin
        warnFlag_q <= 1'b0;
      end
    end
  end

  assign spiDataOut    = spiDataOut_q;
  assign regRailOutOn  = regRailOutOn_q;
  assign batRailOutOn  = batRailOutOn_q;
  assign failSafe      = failSafe_q;
  assign interruptOutN = interruptOutN_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_rail_calm;
    standbyMode && !regRailUv && !regRailOv && !main5vUv;
  endsequence

  a_fail_safe_off: assert property (failNow |=> failSafe_q && !regRailOutOn_q
                                    && !batRailOutOn_q)
    else $error("fail-safe did not turn all outputs off");
  a_standby_unlock: assert property (s_rail_calm [*2] |=> regRailOutOn_q)
    else $error("lockout held outputs off in standby");
  a_warn_raise: assert property (warnNow |=> !interruptOutN_q && warnFlag_q)
    else $error("early warning missed interrupt or flag");
  a_warn_disabled: assert property (warnTh_q == 10'h000 |=> interruptOutN_q)
    else $error("interrupt raised with zero threshold");

  // Each enabled cut reaches its pin two edges after the fault is seen
  sequence s_reg_ov_armed;
    regRailOv && regOvCutEn;
  endsequence
  sequence s_reg_uv_armed;
    regRailUv && regUvCutEn;
  endsequence
  sequence s_bat_ov_armed;
    batRailOv && (batOvCutEn || chargePumpLow);
  endsequence
  sequence s_bat_uv_armed;
    batRailUv && batUvCutEn;
  endsequence
  a_reg_ov_cut: assert property (s_reg_ov_armed |=> ##1 !regRailOutOn_q)
    else $error("regulator rail kept on through enabled overvoltage");
  a_reg_uv_cut: assert property (s_reg_uv_armed |=> ##1 !regRailOutOn_q)
    else $error("regulator rail kept on through enabled undervoltage");
  a_bat_ov_cut: assert property (s_bat_ov_armed |=> ##1 !batRailOutOn_q)
    else $error("battery rail kept on through overvoltage cut");
  a_bat_uv_cut: assert property (s_bat_uv_armed |=> ##1 !batRailOutOn_q)
    else $error("battery rail kept on through enabled undervoltage");

  // A disabled overvoltage cut must not touch the guard on its own; regulator undervoltage fail-safe check
  a_reg_ov_pass: assert property (regRailOv && !regRailUv && !regOvCutEn && !regLockEff
                                  |=> regGuardOn)
    else $error("regulator rail cut with overvoltage cut disabled");
  a_bat_ov_pass: assert property (batRailOv && !batRailUv && !batOvCutEn && !chargePumpLow
                                  && !batLockEff |=> batGuardOn)
    else $error("battery rail cut with charge pump still sufficient");
  a_fail_safe_reg: assert property (main5vUv && regRailUv
                                    |=> failSafe_q && !regRailOutOn_q)
    else $error("regulator undervoltage fail-safe missed");

  // Standby, interrupt and register checks
  a_standby_lockless: assert property (standbyMode |-> !regLockEff && !batLockEff)
    else $error("lockout still effective in standby");
  a_warn_idle: assert property (!activeMode |=> interruptOutN_q)
    else $error("interrupt raised outside active mode");
  a_warn_sticky: assert property (warnFlag_q && !(wrStat && wrData[srsc_pkg::ST_WARN_BIT])
                                  |=> warnFlag_q)
    else $error("warning flag dropped without a clear");
  a_ctrl_write: assert property (wrCtrl |=> ctrlWord == ($past(wrData) & 24'hFC03FF))
    else $error("control register write not stored");

endmodule // srsc_top

// ===== hw/srsc_pkg.sv
package srsc_pkg;

  // Serial frame layout: one header byte, then 24 data bits, MSB first
  localparam int unsigned FRAME_BITS  = 32;
  localparam int unsigned HEAD_BITS   = 8;
  localparam int unsigned DATA_BITS   = 24;
  localparam logic [5:0]  FRAME_LAST  = 6'h20;
  localparam logic [5:0]  HEAD_LAST   = 6'h07;
  localparam int unsigned OP_HI       = 31;
  localparam int unsigned OP_LO       = 30;
  localparam int unsigned ADDR_HI     = 29;
  localparam int unsigned ADDR_LO     = 24;
  localparam logic [1:0]  OP_WRITE    = 2'h0;
  localparam logic [1:0]  OP_READ     = 2'h1;

  // Register offsets
  localparam logic [5:0]  SUPPLY_CTRL_OFFS = 6'h03;
  localparam logic [5:0]  SECOND_STAT_OFFS = 6'h32;

  // Supply supervision control fields
  localparam int unsigned REG_LOCK_BIT   = 23;
  localparam int unsigned BAT_LOCK_BIT   = 22;
  localparam int unsigned REG_OV_CUT_BIT = 21;
  localparam int unsigned REG_UV_CUT_BIT = 20;
  localparam int unsigned BAT_OV_CUT_BIT = 19;
  localparam int unsigned BAT_UV_CUT_BIT = 18;
  localparam int unsigned WARN_TH_HI     = 9;
  localparam int unsigned WARN_TH_LO     = 0;
  localparam int unsigned WARN_TH_W      = 10;
  localparam logic [5:0]  CUT_FIELDS_RST = 6'h3F;
  localparam logic [9:0]  WARN_TH_RST    = 10'h000;

  // Second status register fields, write one to clear
  localparam int unsigned ST_WARN_BIT   = 0;
  localparam int unsigned ST_REG_UV_BIT = 1;
  localparam int unsigned ST_REG_OV_BIT = 2;
  localparam int unsigned ST_BAT_UV_BIT = 3;
  localparam int unsigned ST_BAT_OV_BIT = 4;

endpackage

// ===== hw/srsc_rail_guard.sv
`timescale 1ns/1ps
// Shutdown, lockout and fault flags for one supervised rail
module srsc_rail_guard (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Comparator levels
  input  wire logic underVolt,
  input  wire logic overVolt,
  input  wire logic chargePumpLow,
  // Settings, lockEn already forced low in standby
  input  wire logic lockEn,
  input  wire logic overCutEn,
  input  wire logic underCutEn,
  // Software clear pulses
  input  wire logic clrUnder,
  input  wire logic clrOver,
  // State
  output logic      underFlag,
  output logic      overFlag,
  output logic      outputsOn
);

  logic underFlag_q;
  logic overFlag_q;
  logic off_q;
  logic cutNow;

  // Overvoltage with cut disabled still cuts once the charge pump runs low
  assign cutNow = (overVolt && (overCutEn || chargePumpLow)) || (underVolt && underCutEn);

  // Flags: a fault wins over any clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      underFlag_q <= 1'b0;
      overFlag_q  <= 1'b0;
    end else begin
      if (underVolt) begin
        underFlag_q <= 1'b1;
      end else if (clrUnder || !lockEn) begin
        underFlag_q <= 1'b0;
      end
      if (overVolt) begin
        overFlag_q <= 1'b1;
      end else if (clrOver || !lockEn) begin
        overFlag_q <= 1'b0;
      end
    end
  end

  // Outputs held off by a cut, and by lockout until both flags are gone
  always_ff @(posedge clk) begin
    if (srst) begin
      off_q <= 1'b0;
    end else if (cutNow) begin
      off_q <= 1'b1;
    end else if (lockEn) begin
      off_q <= off_q && (underFlag_q || overFlag_q);
    end else begin
      off_q <= 1'b0;
    end
  end

  assign underFlag = underFlag_q;
  assign overFlag  = overFlag_q;
  assign outputsOn = !off_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_cut_turns_off: assert property (cutNow |=> off_q)
    else $error("rail outputs not cut on enabled fault");
  a_lock_holds: assert property (off_q && lockEn && !clrUnder && !clrOver && underFlag_q
                                 |=> off_q)
    else $error("lockout released with flag still set");
  a_auto_restore: assert property (!lockEn && !underVolt && !overVolt
                                   |=> !off_q && !underFlag_q && !overFlag_q)
    else $error("outputs or flags not restored without lockout");
  a_set_wins: assert property (underVolt && clrUnder |=> underFlag_q)
    else $error("undervoltage flag lost to clear");

endmodule // srsc_rail_guard

// ===== test/srsc_host.sv
`timescale 1ns/1ps
// Host side of the serial register port, driven on falling clk edges
module srsc_host (
  // Clock
  input  wire logic clk,
  // Serial port
  output logic      spiCsN,
  output logic      spiClk,
  output logic      spiDataIn,
  input  wire logic spiDataOut
);
  int halfCyc = 2; // Phase length in cycles, raised to act slowly

  // Idle levels at time zero
  initial begin
    spiCsN    = 1'b1;
    spiClk    = 1'b0;
    spiDataIn = 1'b0;
  end

  // One whole frame; read bits are taken late in each high phase
  task automatic xfer(input logic [1:0] op, input logic [5:0] adr,
                      input logic [23:0] wd, output logic [23:0] rd);
    logic [31:0] frm;
    frm    = {op, adr, wd};
    rd     = 24'h000000;
    spiCsN = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      spiDataIn = frm[i];
      @(negedge clk);
      spiClk = 1'b1;
      repeat (halfCyc) @(negedge clk);
      if (i < 24) rd = {rd[22:0], spiDataOut};
      spiClk = 1'b0;
      repeat (halfCyc) @(negedge clk);
    end
    // Idle data line flips so no stale bit looks valid
    spiCsN    = 1'b1;
    spiDataIn = ~spiDataIn;
    repeat (3) @(negedge clk);
  endtask
endmodule // srsc_host

// ===== test/srsc_top_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the supply supervision block
module srsc_top_tb;
  logic        clk = 1'b0;
  logic        srst;
  logic        spiCsN, spiClk, spiDataIn, spiDataOut;
  logic [3:0]  flt; // Bat OV, bat UV, reg OV, reg UV
  logic        charge_pump_low_threshold, v5Uv, actMode, stbyMode;
  logic [9:0]  code;
  logic        regOn, batOn, failSafe, intN, rail;
  logic [23:0] rdv, ctl;
  int          nErrors = 0;
  int          testsRun = 0;
  localparam logic [5:0] CTRL = srsc_pkg::SUPPLY_CTRL_OFFS;
  localparam logic [5:0] STAT = srsc_pkg::SECOND_STAT_OFFS;
  localparam int CUTB [4] = '{20, 21, 18, 19};

  // 40 MHz clock
  always #12.5 clk = ~clk;

  srsc_top u_srsc_top (
    .clk(clk), .srst(srst), .spiCsN(spiCsN), .spiClk(spiClk),
    .spiDataIn(spiDataIn), .spiDataOut(spiDataOut),
    .regRailUv(flt[0]), .regRailOv(flt[1]), .batRailUv(flt[2]),
    .batRailOv(flt[3]), .chargePumpLow(charge_pump_low_threshold), .main5vUv(v5Uv),
    .regSupplyCode(code), .activeMode(actMode), .standbyMode(stbyMode),
    .regRailOutOn(regOn), .batRailOutOn(batOn), .failSafe(failSafe),
    .interruptOutN(intN)
  );

  srsc_host u_srsc_host (
    .clk(clk), .spiCsN(spiCsN), .spiClk(spiClk),
    .spiDataIn(spiDataIn), .spiDataOut(spiDataOut)
  );

  // Compare and count
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    logic [23:0] x;
    u_srsc_host.xfer(srsc_pkg::OP_WRITE, a, d, x);
  endtask

  task automatic rd(input logic [5:0] a, output logic [23:0] d);
    u_srsc_host.xfer(srsc_pkg::OP_READ, a, 24'h000000, d);
  endtask

  // Longer than the two-cycle cut latency
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask

  task automatic endt(input string n);
    $display("test %s done", n);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    nErrors++;
    $display("BAD watchdog exp done got hang");
    finish_test();
  end

  // Main sequence
  initial begin
    {flt, charge_pump_low_threshold, v5Uv, stbyMode} = 7'h00;
    actMode = 1'b1;
    code    = 10'h3FF;
    srst    = 1'b1;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    settle();
    chk("intNRst", 24'h1, intN);
    rd(CTRL, rdv);
    chk("ctrlRst", 24'hFC0000, rdv);
    wr(CTRL, 24'hFFFFFF);
    rd(CTRL, rdv);
    chk("ctrlRw", 24'hFC03FF, rdv);
    u_srsc_host.halfCyc = 3;
    rd(6'h3F, rdv);
    chk("unmapped", 24'h0, rdv);
    u_srsc_host.halfCyc = 2;
    u_srsc_host.xfer(2'h3, CTRL, 24'h000000, rdv);
    rd(CTRL, rdv);
    chk("badOpKept", 24'hFC03FF, rdv);
    endt("regs");
    // Each fault with cut off, cut on, cut on plus lockout
    for (int i = 0; i < 4; i++) begin
      for (int m = 0; m < 3; m++) begin
        ctl = 24'h000000;
        if (m > 0) ctl[CUTB[i]] = 1'b1;
        if (m == 2) ctl[i < 2 ? 23 : 22] = 1'b1;
        wr(CTRL, ctl);
        flt[i] = 1'b1;
        settle();
        rail = (i < 2) ? regOn : batOn;
        chk("onInFault", 24'(m == 0), rail);
        // A clear while the fault stands must lose to it
        if (m == 2) wr(STAT, 24'h00001E);
        flt[i] = 1'b0;
        settle();
        rail = (i < 2) ? regOn : batOn;
        chk("onAfterFault", 24'(m != 2), rail);
        if (m == 2) begin
          rd(STAT, rdv);
          chk("flagSet", 24'h1, rdv[i+1]);
          wr(STAT, 24'h00001E);
          settle();
          rail = (i < 2) ? regOn : batOn;
          chk("onCleared", 24'h1, rail);
        end
      end
    end
    endt("cuts");
    // Battery overvoltage with cut off, charge pump low
    wr(CTRL, 24'h000000);
    flt[3] = 1'b1;
    charge_pump_low_threshold  = 1'b1;
    settle();
    chk("cpLowOff", 24'h0, batOn);
    {flt[3], charge_pump_low_threshold} = 2'b00;
    // Main regulator undervoltage from either rail
    for (int j = 0; j < 2; j++) begin
      flt  = j ? 4'b0100 : 4'b0001;
      v5Uv = 1'b1;
      settle();
      chk("failSafe", 24'h1, failSafe);
      chk("fsRegOff", 24'h0, regOn);
      chk("fsBatOff", 24'h0, batOn);
      {flt, v5Uv} = 5'h00;
      settle();
    end
    endt("failsafe");
    // Standby drops lockout
    wr(CTRL, 24'hFC0000);
    {actMode, stbyMode} = 2'b01;
    flt[1] = 1'b1;
    settle();
    flt[1] = 1'b0;
    settle();
    chk("stbyRestore", 24'h1, regOn);
    wr(STAT, 24'h00001F);
    {actMode, stbyMode} = 2'b10;
    endt("standby");
    // Early warning threshold and interrupt
    wr(CTRL, 24'h000200);
    code = 10'h1FF;
    settle();
    chk("intBelow", 24'h0, intN);
    code = 10'h200;
    settle();
    chk("intAt", 24'h1, intN);
    rd(STAT, rdv);
    chk("warnFlag", 24'h1, rdv[0]);
    wr(STAT, 24'h000001);
    rd(STAT, rdv);
    chk("warnClr", 24'h0, rdv[0]);
    wr(CTRL, 24'h0003FF);
    code = 10'h3FE;
    settle();
    chk("intFull", 24'h0, intN);
    actMode = 1'b0;
    settle();
    chk("intIdle", 24'h1, intN);
    actMode = 1'b1;
    wr(CTRL, 24'h000000);
    code = 10'h000;
    settle();
    chk("intOff", 24'h1, intN);
    endt("warning");
    finish_test();
  end
endmodule // srsc_top_tb
